// >>> core/plld_pkg.sv
// constants, register map and field layout of the pll lock detector
package plld_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_STAT_ABL = 8'h17;
   localparam logic [7:0] OFS_LOCK_CFG = 8'h18;
   localparam logic [7:0] OFS_DLY = 8'h19;
   localparam logic [7:0] OFS_LPIN = 8'h1a;
   localparam logic [7:0] OFS_REF_MON = 8'h1b;
   localparam logic [7:0] OFS_CMP = 8'h1d;
   localparam logic [7:0] OFS_LK_STAT = 8'h1f;
   localparam logic [7:0] OFS_OE_LO = 8'hfc;
   localparam logic [7:0] OFS_OE_HI = 8'hfd;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_STAT_ABL = 8'h00;
   localparam logic [7:0] RST_LOCK_CFG = 8'h00;
   localparam logic [7:0] RST_DLY = 8'h00;
   localparam logic [7:0] RST_LPIN = 8'h00;
   localparam logic [7:0] RST_REF_MON = 8'h00;
   localparam logic [7:0] RST_CMP = 8'h00;
   localparam logic [7:0] RST_OE = 8'h00;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ABL_LSB = 0;
   localparam int STAT_SEL_LSB = 2;
   localparam int LOCK_CNT_LSB = 5;
   localparam int WIN_BIT = 4;
   localparam int DIS_BIT = 3;
   localparam int RDLY_LSB = 0;
   localparam int NDLY_LSB = 3;
   localparam int LPIN_LSB = 0;
   localparam int REF_MON_LSB = 0;
   localparam int CMP_EN_BIT = 3;
   // ----------------------------------------------------------------
   // pin selection codes
   // ----------------------------------------------------------------
   localparam logic [5:0] LPIN_IND = 6'h01;
   localparam logic [5:0] LPIN_PULSE_P = 6'h02;
   localparam logic [5:0] LPIN_PULSE_N = 6'h03;
   localparam logic [5:0] LPIN_CSRC = 6'h04;
   localparam logic [5:0] STAT_SEL_IND = 6'h01;
   localparam logic [5:0] STAT_SEL_CMP = 6'h02;
   localparam logic [4:0] REF_MON_SEL_IND = 5'h01;
   localparam logic [4:0] REF_MON_SEL_CMP = 5'h02;
   // ----------------------------------------------------------------
   // lock counts and window timing
   // ----------------------------------------------------------------
   localparam logic [7:0] LK_CNT0 = 8'h05;
   localparam logic [7:0] LK_CNT1 = 8'h10;
   localparam logic [7:0] LK_CNT2 = 8'h40;
   localparam logic [7:0] LK_CNT3 = 8'hff;
   localparam int CLK_PERIOD_NS = 100;
   localparam int LOCK_HI_NS = 300;
   localparam int UNLOCK_HI_NS = 700;
   localparam int LOCK_LO_NS = 100;
   localparam int UNLOCK_LO_NS = 300;
   localparam int ABL_STEP_NS = 100;
   localparam int LOCK_HI_CYC = LOCK_HI_NS / CLK_PERIOD_NS;
   localparam int UNLOCK_HI_CYC = UNLOCK_HI_NS / CLK_PERIOD_NS;
   localparam int LOCK_LO_CYC = LOCK_LO_NS / CLK_PERIOD_NS;
   localparam int UNLOCK_LO_CYC = UNLOCK_LO_NS / CLK_PERIOD_NS;
   localparam int ABL_STEP_CYC = ABL_STEP_NS / CLK_PERIOD_NS;
   localparam int OE_W = 16;
endpackage

// >>> core/plld_lock_detect.sv
// digital and analog lock detection, lock pin drive and output gating
`timescale 1ns/10ps
module plld_lock_detect (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // register port
   input wire logic [plld_pkg::ADDR_W-1:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WE_I,
   input wire logic REG_RE_I,
   output logic [7:0] REG_RDATA_O,
   // phase detector edges
   input wire logic REF_EDGE_I,
   input wire logic FB_EDGE_I,
   output logic REF_EVT_O,
   output logic FB_EVT_O,
   // lock pin
   input wire logic LOCK_CMP_I,
   output logic LOCK_PIN_O,
   output logic LOCK_PIN_OE_O,
   output logic CSRC_EN_O,
   // status pins
   output logic STATUS_O,
   output logic REF_MON_O,
   // clock output enables
   input wire logic [plld_pkg::OE_W-1:0] OUT_EN_REQ_I,
   output logic [plld_pkg::OE_W-1:0] OUT_EN_O
);
   import plld_pkg::*;

   typedef enum {PH_IDLE, PH_WAIT_FB, PH_WAIT_REF} plld_phase_type;

   logic [7:0] stat_abl_q, lock_cfg_q, dly_q, lpin_q, ref_mon_q, cmp_q, oe_lo_q, oe_hi_q;
   logic [7:0] rdata_d;
   logic lock_ind_q, csl;

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         stat_abl_q <= RST_STAT_ABL;
         lock_cfg_q <= RST_LOCK_CFG;
         dly_q <= RST_DLY;
         lpin_q <= RST_LPIN;
         ref_mon_q <= RST_REF_MON;
         cmp_q <= RST_CMP;
         oe_lo_q <= RST_OE;
         oe_hi_q <= RST_OE;
      end else if (REG_WE_I) begin
         case (REG_ADDR_I)
            OFS_STAT_ABL: stat_abl_q <= REG_WDATA_I;
            OFS_LOCK_CFG: lock_cfg_q <= REG_WDATA_I;
            OFS_DLY: dly_q <= REG_WDATA_I;
            OFS_LPIN: lpin_q <= REG_WDATA_I;
            OFS_REF_MON: ref_mon_q <= REG_WDATA_I;
            OFS_CMP: cmp_q <= REG_WDATA_I;
            OFS_OE_LO: oe_lo_q <= REG_WDATA_I;
            OFS_OE_HI: oe_hi_q <= REG_WDATA_I;
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      case (REG_ADDR_I)
         OFS_STAT_ABL: rdata_d = stat_abl_q;
         OFS_LOCK_CFG: rdata_d = lock_cfg_q;
         OFS_DLY: rdata_d = dly_q;
         OFS_LPIN: rdata_d = lpin_q;
         OFS_REF_MON: rdata_d = ref_mon_q;
         OFS_CMP: rdata_d = cmp_q;
         OFS_OE_LO: rdata_d = oe_lo_q;
         OFS_OE_HI: rdata_d = oe_hi_q;
         OFS_LK_STAT: rdata_d = {6'h00, csl, lock_ind_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RE_I) begin
         REG_RDATA_O <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // divider delay cells, whole-cycle steps of the system clock
   // ----------------------------------------------------------------
   logic [1:0] edge_in, edge_dly;
   logic [2:0] dly_sel [2];
   logic [6:0] dly_sr_q [2];
   assign edge_in = {FB_EDGE_I, REF_EDGE_I};
   assign dly_sel[0] = dly_q[RDLY_LSB +: 3];
   assign dly_sel[1] = dly_q[NDLY_LSB +: 3];

   for (genvar g = 0; g < 2; g++) begin : g_dly
      always_ff @(posedge CLK_I) begin
         if (RESET_I) begin
            dly_sr_q[g] <= 7'h00;
         end else begin
            dly_sr_q[g] <= {dly_sr_q[g][5:0], edge_in[g]};
         end
      end
      assign edge_dly[g] = (dly_sel[g] == 3'h0) ? edge_in[g] : dly_sr_q[g][3'(dly_sel[g] - 3'h1)];
   end
   assign REF_EVT_O = edge_dly[0];
   assign FB_EVT_O = edge_dly[1];

   // ----------------------------------------------------------------
   // window thresholds
   // ----------------------------------------------------------------
   logic [7:0] lock_thr, unlock_thr, abl_add, lock_req;
   assign abl_add = 8'(int'(stat_abl_q[ABL_LSB +: 2]) * ABL_STEP_CYC);
   // the unlock window grows with the lock window so the gap between them stays
   assign lock_thr = (lock_cfg_q[WIN_BIT] ? 8'(LOCK_LO_CYC) : 8'(LOCK_HI_CYC)) + abl_add;
   assign unlock_thr = (lock_cfg_q[WIN_BIT] ? 8'(UNLOCK_LO_CYC) : 8'(UNLOCK_HI_CYC)) + abl_add;

   always_comb begin
      case (lock_cfg_q[LOCK_CNT_LSB +: 2])
         2'h0: lock_req = LK_CNT0;
         2'h1: lock_req = LK_CNT1;
         2'h2: lock_req = LK_CNT2;
         default: lock_req = LK_CNT3;
      endcase
   end

   // ----------------------------------------------------------------
   // edge separation measurement
   // ----------------------------------------------------------------
   plld_phase_type ph_q;
   logic [7:0] sep_q;
   logic smp_vld, smp_far, smp_in;
   logic [7:0] smp_sep;

   always_comb begin
      smp_vld = 1'b0;
      smp_sep = sep_q;
      case (ph_q)
         PH_IDLE: begin
            smp_vld = edge_dly[0] & edge_dly[1];
            smp_sep = 8'h00;
         end
         PH_WAIT_FB: smp_vld = edge_dly[1] | (sep_q > unlock_thr);
         PH_WAIT_REF: smp_vld = edge_dly[0] | (sep_q > unlock_thr);
         default: smp_vld = 1'b0;
      endcase
   end
   assign smp_in = smp_sep < lock_thr;
   assign smp_far = smp_sep > unlock_thr;

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ph_q <= PH_IDLE;
         sep_q <= 8'h00;
      end else begin
         case (ph_q)
            PH_IDLE: begin
               sep_q <= 8'h01;
               if (edge_dly[0] && !edge_dly[1]) begin
                  ph_q <= PH_WAIT_FB;
               end else if (edge_dly[1] && !edge_dly[0]) begin
                  ph_q <= PH_WAIT_REF;
               end
            end
            PH_WAIT_FB, PH_WAIT_REF: begin
               if (smp_vld) begin
                  ph_q <= PH_IDLE;
               end else begin
                  sep_q <= 8'(sep_q + 8'h01);
               end
            end
            default: ph_q <= PH_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // lock qualification
   // ----------------------------------------------------------------
   logic [7:0] run_q;
   always_ff @(posedge CLK_I) begin
      if (RESET_I || lock_cfg_q[DIS_BIT]) begin
         run_q <= 8'h00;
         lock_ind_q <= 1'b0;
      end else if (smp_vld) begin
         if (smp_far) begin
            run_q <= 8'h00;
            lock_ind_q <= 1'b0;
         end else if (smp_in) begin
            run_q <= (run_q == 8'hff) ? run_q : 8'(run_q + 8'h01);
            if (8'(run_q + 8'h01) >= lock_req) begin
               lock_ind_q <= 1'b1;
            end
         end else if (!lock_ind_q) begin
            // between windows: breaks a run only while unlocked; a held lock keeps its run
            run_q <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // lock pin, status pins and output gating
   // ----------------------------------------------------------------
   logic [5:0] lpin_mode;
   logic phase_open;
   assign lpin_mode = lpin_q[LPIN_LSB +: 6];
   assign phase_open = (ph_q != PH_IDLE);
   // a disabled comparator reads as locked so gated outputs are not stuck off
   assign csl = cmp_q[CMP_EN_BIT] ? LOCK_CMP_I : 1'b1;

   always_comb begin
      LOCK_PIN_O = 1'b0;
      LOCK_PIN_OE_O = 1'b0;
      CSRC_EN_O = 1'b0;
      case (lpin_mode)
         LPIN_IND: begin
            LOCK_PIN_O = lock_ind_q;
            LOCK_PIN_OE_O = 1'b1;
         end
         LPIN_PULSE_N: LOCK_PIN_OE_O = phase_open;
         LPIN_PULSE_P: begin
            LOCK_PIN_O = phase_open;
            LOCK_PIN_OE_O = phase_open;
         end
         LPIN_CSRC: begin
            CSRC_EN_O = lock_ind_q;
            LOCK_PIN_OE_O = !lock_ind_q;
         end
         default: LOCK_PIN_OE_O = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         STATUS_O <= 1'b0;
         REF_MON_O <= 1'b0;
      end else begin
         STATUS_O <= (stat_abl_q[STAT_SEL_LSB +: 6] == STAT_SEL_IND) ? lock_ind_q :
                     (stat_abl_q[STAT_SEL_LSB +: 6] == STAT_SEL_CMP) & csl;
         REF_MON_O <= (ref_mon_q[REF_MON_LSB +: 5] == REF_MON_SEL_IND) ? lock_ind_q :
                      (ref_mon_q[REF_MON_LSB +: 5] == REF_MON_SEL_CMP) & csl;
      end
   end

   assign OUT_EN_O = OUT_EN_REQ_I & ~({oe_hi_q, oe_lo_q} & {OE_W{~csl}});

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_good_smp;
      smp_vld && smp_in && !smp_far && !lock_cfg_q[DIS_BIT];
   endsequence
   sequence s_five_run;
      (lock_cfg_q[LOCK_CNT_LSB +: 2] == 2'h0 && run_q == 8'h04) ##0 s_good_smp;
   endsequence

   five_cycle_lock_a: assert property (s_five_run |=> lock_ind_q)
      else $error("lock not reported after five in-window cycles");
   lock_cause_a: assert property ($rose(lock_ind_q) |->
      $past(smp_vld && smp_in) && $past(run_q) >= 8'(lock_req - 8'h01))
      else $error("lock rose without a full in-window run");
   unlock_one_a: assert property (lock_ind_q && smp_vld && smp_far && !lock_cfg_q[DIS_BIT] |=>
      !lock_ind_q && run_q == 8'h00)
      else $error("lock held after a gap beyond unlock");
   lock_hold_a: assert property ($fell(lock_ind_q) |-> $past(lock_cfg_q[DIS_BIT] || (smp_vld && smp_far)))
      else $error("lock dropped without an unlock cause");
   window_order_a: assert property (unlock_thr > lock_thr)
      else $error("unlock window not wider than lock window");
   disable_clear_a: assert property (lock_cfg_q[DIS_BIT] |=> !lock_ind_q)
      else $error("lock indicator active while detector disabled");
   ref_delay_a: assert property (dly_sel[0] == 3'h3 && REF_EDGE_I ##1 dly_sel[0] == 3'h3 [*3] |-> REF_EVT_O)
      else $error("reference delay cell wrong length");
   csrc_ground_a: assert property (lpin_mode == LPIN_CSRC && $fell(lock_ind_q) |->
      !CSRC_EN_O && LOCK_PIN_OE_O && !LOCK_PIN_O)
      else $error("lock pin not grounded when lock lost");
   gate_off_a: assert property (cmp_q[CMP_EN_BIT] && !LOCK_CMP_I |-> (OUT_EN_O & {oe_hi_q, oe_lo_q}) == 16'h0000)
      else $error("gated output enabled without solid lock");
   status_lock_a: assert property (stat_abl_q[STAT_SEL_LSB +: 6] == STAT_SEL_IND |=>
      STATUS_O == $past(lock_ind_q))
      else $error("status pin does not follow lock indicator");
   sep_zero_a: assert property (ph_q == PH_IDLE && edge_dly[0] && edge_dly[1] |-> smp_vld && smp_sep == 8'h00)
      else $error("coincident edges not taken as zero gap");
endmodule // plld_lock_detect

// >>> verification/plld_cap_model.sv
// lock pin capacitor with its level comparator, fitted outside the detector
`timescale 1ns/10ps
module plld_cap_model #(
   parameter int CHARGE_CYC = 60
) (
   // clock
   input wire logic clk_i,
   // lock pin
   input wire logic pin_i,
   input wire logic pin_oe_i,
   input wire logic csrc_en_i,
   // comparator
   output logic cmp_o
);
   // ----
   // cap level in charge steps; an undriven cap keeps its charge
   // ----
   int level_q = 0;
   always_ff @(posedge clk_i) begin
      if (csrc_en_i) begin
         level_q <= (level_q < CHARGE_CYC) ? level_q + 1 : level_q;
      end else if (pin_oe_i) begin
         level_q <= pin_i ? CHARGE_CYC : 0;
      end
   end
   assign cmp_o = (level_q >= CHARGE_CYC);
endmodule // plld_cap_model

// >>> verification/testbench.sv
// random and corner-case bench for the lock detector
`timescale 1ns/10ps
module testbench;
   import plld_pkg::*;
   // ----
   // signals and instances
   // ----
   logic clk, rst, we, re, ref_e, fb_e, cmp, pin, pin_oe, csrc, stat, ref_mon, ref_evt, fb_evt;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wd, rdata, d, v;
   logic [OE_W-1:0] req, oen, gate;
   int bad_count, num_checks, kr, kf, dr, df;
   logic [7:0] ofs [8] = '{OFS_STAT_ABL, OFS_LOCK_CFG, OFS_DLY, OFS_LPIN, OFS_REF_MON, OFS_CMP, OFS_OE_LO, OFS_OE_HI};
   int cnts [4] = '{LK_CNT0, LK_CNT1, LK_CNT2, LK_CNT3};
   plld_lock_detect i_dut (.CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_WE_I(we),
      .REG_RE_I(re), .REG_RDATA_O(rdata), .REF_EDGE_I(ref_e), .FB_EDGE_I(fb_e), .REF_EVT_O(ref_evt),
      .FB_EVT_O(fb_evt), .LOCK_CMP_I(cmp), .LOCK_PIN_O(pin), .LOCK_PIN_OE_O(pin_oe), .CSRC_EN_O(csrc),
      .STATUS_O(stat), .REF_MON_O(ref_mon), .OUT_EN_REQ_I(req), .OUT_EN_O(oen));
   plld_cap_model i_cap (.clk_i(clk), .pin_i(pin), .pin_oe_i(pin_oe), .csrc_en_i(csrc), .cmp_o(cmp));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----
   // tasks
   // ----
   function automatic int lk(input int w, input int a);
      return (w ? 1 : 3) + a;
   endfunction
   function automatic int ul(input int w, input int a);
      return (w ? 3 : 7) + a;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(negedge clk);
      addr = a;
      wd = x;
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      @(negedge clk);
      addr = a;
      re = 1'b1;
      @(negedge clk);
      re = 1'b0;
      @(posedge clk);
      #1 x = rdata;
   endtask
   // one ref edge and one fb edge g cycles later, then a long quiet gap
   task automatic pr(input int g);
      @(negedge clk);
      ref_e = 1'b1;
      fb_e = (g == 0);
      for (int i = 1; i <= g; i++) begin
         @(negedge clk);
         ref_e = 1'b0;
         fb_e = (i == g);
      end
      @(negedge clk);
      ref_e = 1'b0;
      fb_e = 1'b0;
      repeat (20) @(negedge clk);
   endtask
   task automatic good(input int n, input int lim);
      repeat (n) pr($urandom_range(lim - 1));
   endtask
   task automatic rs();
      @(negedge clk);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #3000000;
      bad_count++;
      summarize();
   end
   // ----
   // tests
   // ----
   initial begin
      {rst, we, re, ref_e, fb_e} = 5'h10;
      addr = '0;
      wd = '0;
      req = '0;
      void'($urandom(94));
      repeat (3) @(negedge clk);
      rst = 1'b0;
      foreach (ofs[i]) begin
         rd(ofs[i], d);
         chk("reset value", 16'h0, 16'(d));
         v = 8'($urandom);
         wr(ofs[i], v);
         rd(ofs[i], d);
         chk("readback", 16'(v), 16'(d));
      end
      wr(8'h20, 8'hff);
      rd(8'h20, d);
      chk("unmapped", 16'h0, 16'(d));
      // first pass is a fixed corner: ref three cycles late, fb at the longest delay
      for (int t = 0; t < 4; t++) begin
         dr = (t == 0) ? 3 : $urandom_range(7);
         df = (t == 0) ? 7 : $urandom_range(7);
         wr(OFS_DLY, 8'(df * 8 + dr));
         @(negedge clk);
         {ref_e, fb_e} = 2'b11;
         kr = 99;
         kf = 99;
         for (int k = 0; k < 10; k++) begin
            #1;
            if (ref_evt === 1'b1 && kr == 99) kr = k;
            if (fb_evt === 1'b1 && kf == 99) kf = k;
            @(negedge clk);
            {ref_e, fb_e} = 2'b00;
         end
         chk("ref delay", 16'(dr), 16'(kr));
         chk("fb delay", 16'(df), 16'(kf));
         repeat (20) @(negedge clk);
      end
      rs();
      wr(OFS_LPIN, 8'(LPIN_IND));
      wr(OFS_REF_MON, 8'(REF_MON_SEL_IND));
      for (int w = 0; w < 2; w++) begin
         for (int a = 0; a < 4; a++) begin
            wr(OFS_LOCK_CFG, 8'(w * 16));
            wr(OFS_STAT_ABL, {STAT_SEL_IND, 2'(a)});
            good(4, lk(w, a));
            pr(lk(w, a));
            good(4, lk(w, a));
            chk("run restart", 16'h0, 16'({stat, ref_mon, pin}));
            good(1, lk(w, a));
            chk("lock pins", 16'h7, 16'({stat, ref_mon, pin}));
            pr(ul(w, a));
            chk("hysteresis", 16'h7, 16'({stat, ref_mon, pin}));
            pr(ul(w, a) + 1);
            chk("unlock", 16'h0, 16'({stat, ref_mon, pin}));
         end
      end
      wr(OFS_STAT_ABL, {STAT_SEL_IND, 2'b00});
      for (int c = 0; c < 4; c++) begin
         wr(OFS_LOCK_CFG, 8'(c * 32));
         good(cnts[c] - 1, 3);
         chk("short run", 16'h0, 16'(stat));
         good(1, 3);
         chk("full run", 16'h1, 16'(stat));
         pr(8);
      end
      wr(OFS_LOCK_CFG, 8'h08);
      good(6, 3);
      chk("disabled", 16'h0, 16'(stat));
      wr(OFS_LOCK_CFG, 8'h00);
      for (int m = 2; m < 4; m++) begin
         wr(OFS_LPIN, 8'(m));
         chk("analog idle", 16'h0, 16'(pin_oe));
         @(negedge clk);
         ref_e = 1'b1;
         @(negedge clk);
         ref_e = 1'b0;
         @(posedge clk);
         #1 chk("analog window", 16'({1'b1, m == 2}), 16'({pin_oe, pin}));
         repeat (20) @(negedge clk);
      end
      gate = OE_W'($urandom);
      req = OE_W'($urandom);
      wr(OFS_LPIN, 8'(LPIN_CSRC));
      wr(OFS_CMP, 8'h08);
      wr(OFS_OE_LO, gate[7:0]);
      wr(OFS_OE_HI, gate[15:8]);
      good(5, 3);
      chk("source on", 16'h1, 16'(csrc));
      chk("gated early", req & ~gate, oen);
      repeat (70) @(negedge clk);
      wr(OFS_STAT_ABL, {STAT_SEL_CMP, 2'b00});
      wr(OFS_REF_MON, 8'(REF_MON_SEL_CMP));
      repeat (2) @(negedge clk);
      chk("comparator pins", 16'h3, 16'({stat, ref_mon}));
      chk("solid enables", req, oen);
      rd(OFS_LK_STAT, d);
      chk("lock status", 16'h3, 16'(d));
      pr(8);
      chk("source off", 16'h2, 16'({csrc, pin_oe, pin}));
      chk("gated late", req & ~gate, oen);
      chk("comparator low", 16'h0, 16'(stat));
      summarize();
   end
endmodule // testbench
